// ### rtl/ssh_map.svh
// constants of the status summary hierarchy: bit positions, masks,
// reset values and error code ranges
// assumes inclusion by bare name from the package and the design modules
`ifndef SSH_MAP_SVH
`define SSH_MAP_SVH

// summary byte bit positions
`define SSH_SB_GROUP_A      0
`define SSH_SB_TRACE        1
`define SSH_SB_ERRQ         2
`define SSH_SB_QUEST        3
`define SSH_SB_MSG          4
`define SSH_SB_STD_SUMMARY  5
`define SSH_SB_SRQ_SUMMARY  6
`define SSH_SB_OPER         7
`define SSH_SB_GROUP_A_BIT  0
// summary byte bits that may request service (bit 6 excluded)
`define SSH_SRQ_SRC_MASK    8'hBF

// standard event latch bit positions
`define SSH_SE_OPC          0
`define SSH_SE_QUERY        2
`define SSH_SE_DEVICE       3
`define SSH_SE_EXEC         4
`define SSH_SE_COMMAND      5
`define SSH_SE_POWER_ON     7
`define SSH_SE_VALID_MASK   8'hBD
`define SSH_SE_RESET        8'h80

// operation group
`define SSH_OP_SWEEP        3
`define SSH_OP_MEASURE      4
`define SSH_OP_SELF_TEST    8
`define SSH_OP_VALID_MASK   16'h0118
`define SSH_GRP_W           16

// status group and summary mask reset values
`define SSH_RISE_RESET      16'h7FFF
`define SSH_FALL_RESET      16'h0000
`define SSH_ENABLE_RESET    16'h0000
`define SSH_MASK8_RESET     8'h00

// error code ranges (inclusive, signed 16 bit)
`define SSH_CMD_ERR_HI      -16'sd100
`define SSH_CMD_ERR_LO      -16'sd199
`define SSH_EXE_ERR_HI      -16'sd200
`define SSH_EXE_ERR_LO      -16'sd299
`define SSH_DEV_ERR_HI      -16'sd300
`define SSH_DEV_ERR_LO      -16'sd399

`endif

// ### rtl/ssh_pkg.sv
// types of the status summary hierarchy: command codes and state records
// assumes ssh_map.svh is on the include path
`include "ssh_map.svh"
package ssh_pkg;

  // command codes decoded from the remote controller's text commands
  typedef enum logic [3:0] {
    SSH_CMD_NOP      = 4'h0,
    SSH_CMD_RD_SB    = 4'h1,
    SSH_CMD_WR_SRM   = 4'h2,
    SSH_CMD_RD_SRM   = 4'h3,
    SSH_CMD_WR_PPM   = 4'h4,
    SSH_CMD_RD_PPM   = 4'h5,
    SSH_CMD_RD_SEL   = 4'h6,
    SSH_CMD_WR_SEM   = 4'h7,
    SSH_CMD_RD_SEM   = 4'h8,
    SSH_CMD_RD_IST   = 4'h9,
    SSH_CMD_RD_OCOND = 4'hA,
    SSH_CMD_RD_OEVT  = 4'hB,
    SSH_CMD_WR_ORISE = 4'hC,
    SSH_CMD_WR_OFALL = 4'hD,
    SSH_CMD_WR_OEN   = 4'hE,
    SSH_CMD_RD_OEN   = 4'hF
  } ssh_cmd_t;

  // state of one status group
  typedef struct packed {
    logic [`SSH_GRP_W-1:0] rise_filter;
    logic [`SSH_GRP_W-1:0] fall_filter;
    logic [`SSH_GRP_W-1:0] enable;
    logic [`SSH_GRP_W-1:0] cond_prev;
    logic [`SSH_GRP_W-1:0] event_latch;
    logic                  summary;
  } ssh_group_state_t;

  // state of the summary block
  typedef struct packed {
    logic [7:0]  service_request_mask;
    logic [7:0]  parallel_poll_mask;
    logic [7:0]  standard_event_mask;
    logic [7:0]  standard_event_latch;
    logic [7:0]  summary_prev;
    logic [7:0]  summary_byte;
    logic        opc_armed;
    logic        srq;
    logic        individual_status_flag;
    logic        rsp_valid;
    logic [15:0] rsp_data;
    logic        err_push;
    logic [15:0] err_code;
  } ssh_state_t;

endpackage : ssh_pkg

// ### rtl/ssh_status_group.sv
// one 16-bit status group: condition, edge filters, event latch, enable
// assumes conditions come from logic on i_clk; writes and reads are pulses
`timescale 1ns/100ps
`default_nettype none
`include "ssh_map.svh"
module ssh_status_group #(
  parameter logic [`SSH_GRP_W-1:0] VALID_MASK = `SSH_OP_VALID_MASK
) (
  // clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_reset,
  // live conditions
  input  wire logic [`SSH_GRP_W-1:0] i_cond,
  // register access
  input  wire logic                  i_wr_rise,
  input  wire logic                  i_wr_fall,
  input  wire logic                  i_wr_enable,
  input  wire logic [`SSH_GRP_W-1:0] i_wdata,
  input  wire logic                  i_rd_event,
  // results
  output logic      [`SSH_GRP_W-1:0] o_cond,
  output logic      [`SSH_GRP_W-1:0] o_event,
  output logic      [`SSH_GRP_W-1:0] o_enable,
  output logic                       o_summary
);

  ssh_pkg::ssh_group_state_t s_reg;
  ssh_pkg::ssh_group_state_t s_next;
  logic [`SSH_GRP_W-1:0]     cond_m;
  logic [`SSH_GRP_W-1:0]     edges;

  // undefined bits and bit 15 read as zero
  assign cond_m = i_cond & VALID_MASK;

  // edge filters, read-clear with set winning, summary
  always_comb begin
    s_next = s_reg;
    edges  = (cond_m & ~s_reg.cond_prev & s_reg.rise_filter)
           | (~cond_m & s_reg.cond_prev & s_reg.fall_filter);
    s_next.cond_prev = cond_m;
    if (i_wr_rise) begin
      s_next.rise_filter = i_wdata & VALID_MASK;
    end
    if (i_wr_fall) begin
      s_next.fall_filter = i_wdata & VALID_MASK;
    end
    if (i_wr_enable) begin
      s_next.enable = i_wdata & VALID_MASK;
    end
    // events since last read; read clears, new edge still lands
    s_next.event_latch = ((i_rd_event ? '0 : s_reg.event_latch) | edges)
                         & VALID_MASK;
    s_next.summary = |(s_next.event_latch & s_next.enable);
  end

  // state register
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      s_reg <= '{rise_filter: `SSH_RISE_RESET & VALID_MASK,
                 fall_filter: `SSH_FALL_RESET, enable: `SSH_ENABLE_RESET,
                 cond_prev: '0, event_latch: '0, summary: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_cond    = s_reg.cond_prev;
  assign o_event   = s_reg.event_latch;
  assign o_enable  = s_reg.enable;
  assign o_summary = s_reg.summary;

  // a rising condition with its filter set is latched next cycle
  AST_GRP_RISE : assert property (@(posedge i_clk) disable iff (i_reset)
    (cond_m[`SSH_OP_MEASURE] && !s_reg.cond_prev[`SSH_OP_MEASURE]
     && s_reg.rise_filter[`SSH_OP_MEASURE])
    |=> o_event[`SSH_OP_MEASURE])
    else $error("rising edge not latched");

endmodule : ssh_status_group
`default_nettype wire

// ### rtl/ssh_top.sv
// status summary hierarchy: summary byte, service request, individual
// status flag, standard event latch and the operation status group
// assumes one clock, decoded register commands arriving as one-cycle
// strobes, and status inputs produced by logic on the same clock
`timescale 1ns/100ps
`default_nettype none
`include "ssh_map.svh"
module ssh_top (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  // decoded register commands
  input  wire logic        i_cmd_valid,
  input  wire logic [3:0]  i_cmd_code,
  input  wire logic [15:0] i_cmd_wdata,
  // summaries of the lower groups
  input  wire logic        i_group_a_summary,
  input  wire logic        i_trace_summary,
  input  wire logic        i_questionable_summary,
  // queue levels
  input  wire logic        i_err_queue_not_empty,
  input  wire logic        i_message_waiting_flag,
  // command engine events
  input  wire logic        i_opc_cmd,
  input  wire logic        i_exec_busy,
  input  wire logic        i_query_error,
  input  wire logic        i_device_error,
  input  wire logic        i_exec_error,
  input  wire logic        i_command_error,
  input  wire logic [15:0] i_err_detail,
  // operation conditions
  input  wire logic        i_sweep_summary,
  input  wire logic        i_measurement_active,
  input  wire logic        i_self_test_active,
  // register answers
  output logic             o_rsp_valid,
  output logic      [15:0] o_rsp_data,
  // status outputs
  output logic      [7:0]  o_summary_byte,
  output logic             o_srq,
  output logic             o_individual_status_flag,
  // error queue push
  output logic             o_err_push,
  output logic      [15:0] o_err_code
);

  ssh_pkg::ssh_state_t   s_reg;
  ssh_pkg::ssh_state_t   s_next;
  ssh_pkg::ssh_cmd_t     cmd;
  logic [`SSH_GRP_W-1:0] oper_cond_in;
  logic [`SSH_GRP_W-1:0] oper_cond;
  logic [`SSH_GRP_W-1:0] oper_event;
  logic [`SSH_GRP_W-1:0] oper_enable;
  logic                  oper_summary;
  logic [7:0]            sb_now;
  logic [7:0]            se_set;
  logic                  opc_fire;

  // strobe test for one command code
  function automatic logic is_cmd(input logic v, input ssh_pkg::ssh_cmd_t c,
                                  input ssh_pkg::ssh_cmd_t want);
    return v && (c == want);
  endfunction : is_cmd

  // keep an error code inside its range, or above zero when allow_pos, else use the range head
  function automatic logic [15:0] fit_code(input logic [15:0] c,
                                           input logic signed [15:0] hi,
                                           input logic signed [15:0] lo,
                                           input logic allow_pos);
    logic signed [15:0] v;
    v = $signed(c);
    if ((v <= hi && v >= lo) || (allow_pos && v > 16'sd0)) begin
      return c;
    end
    return hi;
  endfunction : fit_code

  assign cmd = ssh_pkg::ssh_cmd_t'(i_cmd_code);

  // operation conditions: only bits 3, 4 and 8 exist
  always_comb begin
    oper_cond_in                    = '0;
    oper_cond_in[`SSH_OP_SWEEP]     = i_sweep_summary;
    oper_cond_in[`SSH_OP_MEASURE]   = i_measurement_active;
    oper_cond_in[`SSH_OP_SELF_TEST] = i_self_test_active;
  end

  // operation status group
  ssh_status_group #(
    .VALID_MASK (`SSH_OP_VALID_MASK)
  ) u_oper (
    .i_clk       (i_clk),
    .i_reset     (i_reset),
    .i_cond      (oper_cond_in),
    .i_wr_rise   (is_cmd(i_cmd_valid, cmd, ssh_pkg::SSH_CMD_WR_ORISE)),
    .i_wr_fall   (is_cmd(i_cmd_valid, cmd, ssh_pkg::SSH_CMD_WR_OFALL)),
    .i_wr_enable (is_cmd(i_cmd_valid, cmd, ssh_pkg::SSH_CMD_WR_OEN)),
    .i_wdata     (i_cmd_wdata),
    .i_rd_event  (is_cmd(i_cmd_valid, cmd, ssh_pkg::SSH_CMD_RD_OEVT)),
    .o_cond      (oper_cond),
    .o_event     (oper_event),
    .o_enable    (oper_enable),
    .o_summary   (oper_summary)
  );

  // standard event sources of this cycle
  always_comb begin
    opc_fire                   = s_reg.opc_armed && !i_exec_busy;
    se_set                     = '0;
    se_set[`SSH_SE_OPC]        = opc_fire;
    se_set[`SSH_SE_QUERY]      = i_query_error;
    se_set[`SSH_SE_DEVICE]     = i_device_error;
    se_set[`SSH_SE_EXEC]       = i_exec_error;
    se_set[`SSH_SE_COMMAND]    = i_command_error;
  end

  // live summary byte built from lower summaries and queue levels
  always_comb begin
    sb_now = '0;
    sb_now[`SSH_SB_GROUP_A_BIT] = i_group_a_summary;
    sb_now[`SSH_SB_TRACE]       = i_trace_summary;
    sb_now[`SSH_SB_ERRQ]        = i_err_queue_not_empty;
    sb_now[`SSH_SB_QUEST]       = i_questionable_summary;
    sb_now[`SSH_SB_MSG]         = i_message_waiting_flag;
    sb_now[`SSH_SB_STD_SUMMARY] =
      |(s_reg.standard_event_latch & s_reg.standard_event_mask);
    sb_now[`SSH_SB_OPER]        = oper_summary;
    // service request summary ignores its own mask bit
    sb_now[`SSH_SB_SRQ_SUMMARY] =
      |(sb_now & s_reg.service_request_mask & `SSH_SRQ_SRC_MASK);
  end

  // next state: masks, latch, service request, poll flag, answers
  always_comb begin
    s_next = s_reg;
    // mask writes; undefined standard event bits stay zero
    if (is_cmd(i_cmd_valid, cmd, ssh_pkg::SSH_CMD_WR_SRM)) begin
      s_next.service_request_mask = i_cmd_wdata[7:0];
    end
    if (is_cmd(i_cmd_valid, cmd, ssh_pkg::SSH_CMD_WR_PPM)) begin
      s_next.parallel_poll_mask = i_cmd_wdata[7:0];
    end
    if (is_cmd(i_cmd_valid, cmd, ssh_pkg::SSH_CMD_WR_SEM)) begin
      s_next.standard_event_mask =
        i_cmd_wdata[7:0] & `SSH_SE_VALID_MASK;
    end
    // completion tracking
    if (i_opc_cmd) begin
      s_next.opc_armed = 1'b1;
    end else if (opc_fire) begin
      s_next.opc_armed = 1'b0;
    end
    // read clears the latch, a new event in that cycle still lands
    s_next.standard_event_latch =
      ((is_cmd(i_cmd_valid, cmd, ssh_pkg::SSH_CMD_RD_SEL)
        ? 8'h00 : s_reg.standard_event_latch) | se_set)
      & `SSH_SE_VALID_MASK;
    // service request on an enabled rising summary bit
    s_next.summary_prev = sb_now;
    s_next.summary_byte = sb_now;
    s_next.srq = |(sb_now & ~s_reg.summary_prev
                   & s_reg.service_request_mask
                   & `SSH_SRQ_SRC_MASK);
    // poll flag uses every bit including bit 6
    s_next.individual_status_flag = |(sb_now & s_reg.parallel_poll_mask);
    // error queue push, one per cycle, command error first
    s_next.err_push = i_command_error | i_exec_error | i_device_error;
    s_next.err_code = s_reg.err_code;
    if (i_command_error) begin
      s_next.err_code = fit_code(i_err_detail, `SSH_CMD_ERR_HI,
                                 `SSH_CMD_ERR_LO, 1'b0);
    end else if (i_exec_error) begin
      s_next.err_code = fit_code(i_err_detail, `SSH_EXE_ERR_HI,
                                 `SSH_EXE_ERR_LO, 1'b0);
    end else if (i_device_error) begin
      s_next.err_code = fit_code(i_err_detail, `SSH_DEV_ERR_HI,
                                 `SSH_DEV_ERR_LO, 1'b1);
    end
    // answers to read commands, one cycle after the strobe
    s_next.rsp_valid = 1'b0;
    s_next.rsp_data  = s_reg.rsp_data;
    if (i_cmd_valid) begin
      case (cmd)
        ssh_pkg::SSH_CMD_RD_SB: begin
          s_next.rsp_valid = 1'b1;
          s_next.rsp_data  = {8'h00, sb_now};
        end
        ssh_pkg::SSH_CMD_RD_SRM: begin
          s_next.rsp_valid = 1'b1;
          s_next.rsp_data  = {8'h00, s_reg.service_request_mask};
        end
        ssh_pkg::SSH_CMD_RD_PPM: begin
          s_next.rsp_valid = 1'b1;
          s_next.rsp_data  = {8'h00, s_reg.parallel_poll_mask};
        end
        ssh_pkg::SSH_CMD_RD_SEL: begin
          s_next.rsp_valid = 1'b1;
          s_next.rsp_data  = {8'h00, s_reg.standard_event_latch};
        end
        ssh_pkg::SSH_CMD_RD_SEM: begin
          s_next.rsp_valid = 1'b1;
          s_next.rsp_data  = {8'h00, s_reg.standard_event_mask};
        end
        ssh_pkg::SSH_CMD_RD_IST: begin
          s_next.rsp_valid = 1'b1;
          s_next.rsp_data  = {15'h0000, s_reg.individual_status_flag};
        end
        ssh_pkg::SSH_CMD_RD_OCOND: begin
          s_next.rsp_valid = 1'b1;
          s_next.rsp_data  = oper_cond;
        end
        ssh_pkg::SSH_CMD_RD_OEVT: begin
          s_next.rsp_valid = 1'b1;
          s_next.rsp_data  = oper_event;
        end
        ssh_pkg::SSH_CMD_RD_OEN: begin
          s_next.rsp_valid = 1'b1;
          s_next.rsp_data  = oper_enable;
        end
        default: begin
          s_next.rsp_valid = 1'b0;
        end
      endcase
    end
  end

  // state register; power-on event is the latch's reset value
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      s_reg <= '{service_request_mask: `SSH_MASK8_RESET,
                 parallel_poll_mask:   `SSH_MASK8_RESET,
                 standard_event_mask:  `SSH_MASK8_RESET,
                 standard_event_latch: `SSH_SE_RESET,
                 summary_prev: 8'h00, summary_byte: 8'h00,
                 opc_armed: 1'b0, srq: 1'b0, individual_status_flag: 1'b0,
                 rsp_valid: 1'b0, rsp_data: 16'h0000,
                 err_push: 1'b0, err_code: 16'h0000};
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state register
  assign o_rsp_valid              = s_reg.rsp_valid;
  assign o_rsp_data               = s_reg.rsp_data;
  assign o_summary_byte           = s_reg.summary_byte;
  assign o_srq                    = s_reg.srq;
  assign o_individual_status_flag = s_reg.individual_status_flag;
  assign o_err_push               = s_reg.err_push;
  assign o_err_code               = s_reg.err_code;

  default clocking ast_cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  // error queue goes from empty to filled while enabled
  sequence seq_errq_rise;
    !sb_now[`SSH_SB_ERRQ] ##1
      (sb_now[`SSH_SB_ERRQ] && s_reg.service_request_mask[`SSH_SB_ERRQ]);
  endsequence

  // completion requested, then engine idle
  sequence seq_opc_done;
    i_opc_cmd ##1 !i_exec_busy;
  endsequence

  AST_SB_GROUP_A : assert property (
    o_summary_byte[`SSH_SB_GROUP_A_BIT] == $past(i_group_a_summary))
    else $error("summary bit 0 does not follow group a");

  AST_SB_MSG : assert property (
    i_message_waiting_flag |=> o_summary_byte[`SSH_SB_MSG])
    else $error("message flag not shown");

  AST_SRQ_ERRQ : assert property (
    seq_errq_rise |=> o_srq)
    else $error("no service request on new error");

  AST_SRQ_QUIET : assert property (
    (sb_now == s_reg.summary_prev) |=> !o_srq)
    else $error("service request without a rising bit");

  AST_IST : assert property (
    ##1 (o_individual_status_flag ==
         |(o_summary_byte & $past(s_reg.parallel_poll_mask))))
    else $error("poll flag mismatch");

  AST_OPC : assert property (
    seq_opc_done |=> s_reg.standard_event_latch[`SSH_SE_OPC])
    else $error("completion bit not set");

  AST_OPC_WAIT : assert property (
    (i_opc_cmd ##1 i_exec_busy[*2]) |-> !se_set[`SSH_SE_OPC])
    else $error("completion bit set while busy");

  AST_CMD_ERR : assert property (
    i_command_error |=> (s_reg.standard_event_latch[`SSH_SE_COMMAND]
      && o_err_push && $signed(o_err_code) <= -16'sd100
      && $signed(o_err_code) >= -16'sd199))
    else $error("command error not recorded");

  AST_RD_CLEAR : assert property (
    (is_cmd(i_cmd_valid, cmd, ssh_pkg::SSH_CMD_RD_SEL) && se_set == 8'h00)
    |=> (s_reg.standard_event_latch == 8'h00 && o_rsp_valid))
    else $error("latch not cleared by read");

  AST_UNDEF_ZERO : assert property (
    (s_reg.standard_event_latch & ~`SSH_SE_VALID_MASK) == 8'h00
    && oper_event[15] == 1'b0)
    else $error("undefined bit set");

endmodule : ssh_top
`default_nettype wire

// ### dv/ssh_ctrl_model.sv
// remote controller model: issues decoded register commands to the block
// assumes commands launch at the falling edge and are taken at the next rise
`timescale 1ns/100ps
`default_nettype none
module ssh_ctrl_model (
  // clock
  input  wire logic        i_clk,
  // command port toward the block
  output logic             o_cmd_valid,
  output logic      [3:0]  o_cmd_code,
  output logic      [15:0] o_cmd_wdata
);
  // idle values at time zero
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd_code  = 4'h0;
    o_cmd_wdata = 16'hA5A5;
  end
  // one command held over one rising edge; released lines show inverted data
  task automatic send(input logic [3:0] code, input logic [15:0] wdata);
    @(negedge i_clk);
    o_cmd_valid <= 1'b1;
    o_cmd_code  <= code;
    o_cmd_wdata <= wdata;
    @(negedge i_clk);
    o_cmd_valid <= 1'b0;
    o_cmd_code  <= ~code;
    o_cmd_wdata <= ~wdata;
  endtask : send
  // status poll made before any error queue fetch
  task automatic poll_status();
    send(4'h1, 16'h0000);
  endtask : poll_status
endmodule : ssh_ctrl_model
`default_nettype wire

// ### dv/test_status_summary_hierarchy.sv
// self-checking bench for the status summary hierarchy top
// assumes the controller model drives commands; queues hold expected answers
`timescale 1ns/100ps
`default_nettype none
module test_status_summary_hierarchy;
  logic        i_clk, i_reset, cmd_valid;
  logic [3:0]  cmd_code;
  logic [15:0] cmd_wdata, i_err_detail, rsp_data, err_code;
  logic        i_ga, i_tr, i_eq, i_qs, i_mw, i_opc, i_busy;
  logic        i_query_error, i_device_error, i_exec_error, i_command_error;
  logic        i_sw, i_ms, i_st, rsp_valid, srq, individual_status_flag, err_push;
  logic [7:0]  sb, ppm;
  logic [15:0] rsp_q[$], err_q[$];
  int          err_total, samples_checked, cycles;
  int          seed = 32'h09AB;
  logic [31:0] r;
  // clock
  always #5 i_clk = ~i_clk;
  ssh_ctrl_model ssh_ctrl_model_i (.i_clk(i_clk), .o_cmd_valid(cmd_valid),
    .o_cmd_code(cmd_code), .o_cmd_wdata(cmd_wdata));
  ssh_top ssh_top_i (.i_clk(i_clk), .i_reset(i_reset), .i_cmd_valid(cmd_valid),
    .i_cmd_code(cmd_code), .i_cmd_wdata(cmd_wdata), .i_group_a_summary(i_ga),
    .i_trace_summary(i_tr), .i_questionable_summary(i_qs),
    .i_err_queue_not_empty(i_eq), .i_message_waiting_flag(i_mw), .i_opc_cmd(i_opc),
    .i_exec_busy(i_busy), .i_query_error(i_query_error), .i_device_error(i_device_error),
    .i_exec_error(i_exec_error), .i_command_error(i_command_error),
    .i_err_detail(i_err_detail), .i_sweep_summary(i_sw), .i_measurement_active(i_ms),
    .i_self_test_active(i_st), .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data),
    .o_summary_byte(sb), .o_srq(srq), .o_individual_status_flag(individual_status_flag),
    .o_err_push(err_push), .o_err_code(err_code));
  // compare one value and count it
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      err_total++;
    end
  endtask : check
  // verdict and end of run
  task automatic complete_run();
    if (rsp_q.size() != 0 || err_q.size() != 0) err_total++;
    if (err_total == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  // read with the expected answer noted first
  task automatic rd(input logic [3:0] code, input logic [15:0] exp);
    rsp_q.push_back(exp);
    ssh_ctrl_model_i.send(code, 16'h0000);
  endtask : rd
  task automatic idle(input int n);
    repeat (n) @(negedge i_clk);
  endtask : idle
  // error pulse: kind 0 query, 1 device, 2 exec, 3 command
  task automatic pulse_err(input int kind, input logic [15:0] det);
    @(negedge i_clk);
    i_err_detail = det;
    {i_command_error, i_exec_error, i_device_error, i_query_error} = 4'b0001 << kind;
    @(negedge i_clk);
    {i_command_error, i_exec_error, i_device_error, i_query_error} = 4'h0;
  endtask : pulse_err
  // watcher: answers and error pushes take the oldest note
  always @(negedge i_clk) begin
    if (rsp_valid === 1'b1) begin
      if (rsp_q.size() == 0) check(rsp_data, ~rsp_data);
      else check(rsp_data, rsp_q.pop_front());
    end
    if (err_push === 1'b1) begin
      if (err_q.size() == 0) check(err_code, ~err_code);
      else check(err_code, err_q.pop_front());
    end
  end
  // hang guard
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      complete_run();
    end
  end
  // main sequence
  initial begin
    static int          kinds[6] = '{3, 2, 1, 1, 2, 0};
    static logic [15:0] dets[6]  = '{-16'sd150, -16'sd250, -16'sd350, 16'h0005, -16'sd50, -16'sd1};
    static logic [15:0] exps[6]  = '{-16'sd150, -16'sd250, -16'sd350, 16'h0005, -16'sd200, 16'h0};
    i_clk = 0; i_reset = 1; i_err_detail = 16'h0;
    {i_ga, i_tr, i_eq, i_qs, i_mw, i_opc, i_busy, i_sw, i_ms, i_st} = 10'h000;
    {i_command_error, i_exec_error, i_device_error, i_query_error} = 4'h0;
    idle(6);
    check({sb, srq, individual_status_flag, err_push, rsp_valid}, 16'h0);
    i_reset = 0;
    rd(ssh_pkg::SSH_CMD_RD_SEL, 16'h0080);
    rd(ssh_pkg::SSH_CMD_RD_SEL, 16'h0000);
    ssh_ctrl_model_i.send(ssh_pkg::SSH_CMD_WR_SEM, 16'h00FF);
    rd(ssh_pkg::SSH_CMD_RD_SEM, 16'h00BD);
    // a no-operation code must give no answer
    ssh_ctrl_model_i.send(ssh_pkg::SSH_CMD_NOP, 16'hFFFF);
    // random lower summaries and poll mask
    for (int k = 0; k < 8; k++) begin
      r = $random(seed);
      ppm = r[15:8];
      ssh_ctrl_model_i.send(ssh_pkg::SSH_CMD_WR_PPM, {8'h00, ppm});
      {i_mw, i_qs, i_eq, i_tr, i_ga} = r[4:0];
      idle(3);
      check(sb, {3'b000, r[4:0]});
      check(individual_status_flag, |({3'b000, r[4:0]} & ppm));
    end
    {i_mw, i_qs, i_eq, i_tr, i_ga} = 5'h00;
    rd(ssh_pkg::SSH_CMD_RD_PPM, {8'h00, ppm});
    ssh_ctrl_model_i.send(ssh_pkg::SSH_CMD_WR_SRM, 16'h0024);
    rd(ssh_pkg::SSH_CMD_RD_SRM, 16'h0024);
    // error queue flag rising raises one service request pulse
    idle(2);
    i_eq = 1'b1;
    idle(1);
    check(srq, 1'b1);
    idle(1);
    check(srq, 1'b0);
    ssh_ctrl_model_i.send(ssh_pkg::SSH_CMD_WR_PPM, 16'h0040);
    for (int k = 0; k < 6; k++) begin
      if (kinds[k] != 0) err_q.push_back(exps[k]);
      pulse_err(kinds[k], dets[k]);
    end
    idle(4);
    check(sb, 8'h64);
    check(individual_status_flag, 1'b1);
    rsp_q.push_back(16'h0064);
    ssh_ctrl_model_i.poll_status();
    rd(ssh_pkg::SSH_CMD_RD_IST, 16'h0001);
    rd(ssh_pkg::SSH_CMD_RD_SEL, 16'h003C);
    i_eq = 1'b0;
    // completion waits for earlier commands
    i_busy = 1'b1;
    i_opc = 1'b1;
    idle(1);
    i_opc = 1'b0;
    idle(5);
    rd(ssh_pkg::SSH_CMD_RD_SEL, 16'h0000);
    i_busy = 1'b0;
    idle(3);
    rd(ssh_pkg::SSH_CMD_RD_SEL, 16'h0001);
    // completion with an idle engine lands one cycle after arming
    i_opc = 1'b1;
    idle(1);
    i_opc = 1'b0;
    idle(2);
    rd(ssh_pkg::SSH_CMD_RD_SEL, 16'h0001);
    // operation group
    ssh_ctrl_model_i.send(ssh_pkg::SSH_CMD_WR_OEN, 16'hFFFF);
    rd(ssh_pkg::SSH_CMD_RD_OEN, 16'h0118);
    {i_sw, i_ms, i_st} = 3'b111;
    idle(3);
    check(sb[7], 1'b1);
    rd(ssh_pkg::SSH_CMD_RD_OCOND, 16'h0118);
    rd(ssh_pkg::SSH_CMD_RD_OEVT, 16'h0118);
    rd(ssh_pkg::SSH_CMD_RD_OEVT, 16'h0000);
    ssh_ctrl_model_i.send(ssh_pkg::SSH_CMD_WR_OFALL, 16'h0010);
    i_ms = 1'b0;
    idle(3);
    rd(ssh_pkg::SSH_CMD_RD_OCOND, 16'h0108);
    rd(ssh_pkg::SSH_CMD_RD_OEVT, 16'h0010);
    ssh_ctrl_model_i.send(ssh_pkg::SSH_CMD_WR_ORISE, 16'h0000);
    i_ms = 1'b1;
    idle(3);
    rd(ssh_pkg::SSH_CMD_RD_OEVT, 16'h0000);
    idle(4);
    complete_run();
  end
endmodule : test_status_summary_hierarchy
`default_nettype wire
